// ### core/acmpc_top.sv
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module acmpc_top
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // analog comparator interface
  input  wire logic        comp_raw,
  output logic             comp_enable,
  output logic             reference_select,
  // pin and interrupt
  output logic             comparator_output_pin,
  output logic             comparator_output_pin_oe,
  output logic             compare_irq
);

  // control fields and compare-event flag
  acmpc_pkg::acmpc_ctrl_t ctrl_ff;
  acmpc_pkg::acmpc_ctrl_t nxt_ctrl;
  logic                   flag_ff;
  logic                   nxt_flag;
  // synchroniser stages and edge history
  logic                   sync1_ff;
  logic                   nxt_sync1;
  logic                   sync2_ff;
  logic                   nxt_sync2;
  logic                   prev_ff;
  logic                   nxt_prev;
  // bus data-phase tracking and read data
  logic                   wr_pend_ff;
  logic                   nxt_wr_pend;
  logic                   wr_sel_ff;
  logic                   nxt_wr_sel;
  logic [31:0]            rdata_ff;
  logic [31:0]            nxt_rdata;
  // decoded terms
  logic                   addr_ok;
  logic                   take;
  logic                   wr_now;
  logic                   rise;
  logic                   fall;
  logic                   event_hit;
  logic                   set_flag;
  logic                   clr_flag;
  logic                   out_state;
  logic [7:0]             sc_view;

  // bus decode; the slave never waits, so every access completes in one data cycle
  assign addr_ok   = (haddr == acmpc_pkg::ACMPC_OFS_SC);
  assign take      = hsel && hready && (htrans == acmpc_pkg::ACMPC_HTRANS_NONSEQ);
  assign wr_now    = wr_pend_ff && wr_sel_ff;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;

  // synchroniser next values; sync1 feeds only sync2, never the edge logic
  always_comb
  begin
    nxt_sync1 = comp_raw;
    nxt_sync2 = sync1_ff; // [R14]
  end

  // synchroniser registers; two stages bound metastability of the analog level
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  // edge history cleared while disabled so enabling never fakes a falling edge
  // a high comparator at enable time gives one rising event, as users expect
  always_comb
  begin
    nxt_prev = 1'b0;
    if (ctrl_ff.enable)
    begin
      nxt_prev = sync2_ff; // [R14]
    end
  end

  // edge history register
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      prev_ff <= 1'b0;
    end
    else
    begin
      prev_ff <= nxt_prev;
    end
  end

  // edges from consecutive synchronised samples only
  assign rise      = sync2_ff && !prev_ff; // [R14]
  assign fall      = !sync2_ff && prev_ff; // [R14]
  // output state bit forced low while disabled; the pin sees the same level while pin_en is set, else it is driven low
  assign out_state = ctrl_ff.enable && sync2_ff; // [R7] [R6] [R10]

  // event selection by mode; the spare falling code shares the default branch
  always_comb
  begin
    case (ctrl_ff.mode) // [R9]
      acmpc_pkg::ACMPC_MODE_RISE: event_hit = rise;
      acmpc_pkg::ACMPC_MODE_BOTH: event_hit = rise || fall;
      default:                    event_hit = fall;
    endcase
  end

  // flag set and clear terms; stop and debug modes have no ports, so no gating
  assign set_flag  = ctrl_ff.enable && event_hit; // [R3] [R15] [R11] [R13]
  assign clr_flag  = wr_now && hwdata[acmpc_pkg::ACMPC_BIT_FLAG]; // [R4]

  // control next values; only the data phase of a mapped write changes them
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    if (wr_now)
    begin
      nxt_ctrl.enable  = hwdata[acmpc_pkg::ACMPC_BIT_EN]; // [R1]
      nxt_ctrl.ref_sel = hwdata[acmpc_pkg::ACMPC_BIT_REF]; // [R2]
      nxt_ctrl.irq_en  = hwdata[acmpc_pkg::ACMPC_BIT_IE]; // [R5]
      nxt_ctrl.pin_en  = hwdata[acmpc_pkg::ACMPC_BIT_PE]; // [R8]
      nxt_ctrl.mode    = hwdata[acmpc_pkg::ACMPC_MODE_HI:acmpc_pkg::ACMPC_MODE_LO]; // [R9]
    end
  end

  // control register; reset also stands for wake from the powered-down stop state
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_ff <= '0; // [R15] [R12]
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // flag next value; set wins over a same-cycle write-one clear so no event is lost
  always_comb
  begin
    nxt_flag = flag_ff;
    if (clr_flag)
    begin
      nxt_flag = 1'b0; // [R4]
    end
    if (set_flag)
    begin
      nxt_flag = 1'b1; // [R3]
    end
  end

  // flag register
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      flag_ff <= 1'b0; // [R15]
    end
    else
    begin
      flag_ff <= nxt_flag;
    end
  end

  // bus next values; read data are captured in the address phase
  // so they stand through the whole data phase without a wait state
  always_comb
  begin
    nxt_wr_pend = take && hwrite;
    nxt_wr_sel  = take && hwrite && addr_ok;
    nxt_rdata   = 32'h0000_0000;
    if (take && !hwrite && addr_ok)
    begin
      nxt_rdata = {24'h00_0000, sc_view};
    end
  end

  // bus registers
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      wr_pend_ff <= 1'b0;
      wr_sel_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_ff <= nxt_wr_pend;
      wr_sel_ff  <= nxt_wr_sel;
      rdata_ff   <= nxt_rdata;
    end
  end

  // register view as software sees it; unused upper bits read zero
  always_comb
  begin
    sc_view = acmpc_pkg::ACMPC_SC_RESET;
    sc_view[acmpc_pkg::ACMPC_BIT_EN]   = ctrl_ff.enable;
    sc_view[acmpc_pkg::ACMPC_BIT_REF]  = ctrl_ff.ref_sel;
    sc_view[acmpc_pkg::ACMPC_BIT_FLAG] = flag_ff;
    sc_view[acmpc_pkg::ACMPC_BIT_IE]   = ctrl_ff.irq_en;
    sc_view[acmpc_pkg::ACMPC_BIT_OUT]  = out_state; // [R6]
    sc_view[acmpc_pkg::ACMPC_BIT_PE]   = ctrl_ff.pin_en;
    sc_view[acmpc_pkg::ACMPC_MODE_HI:acmpc_pkg::ACMPC_MODE_LO] = ctrl_ff.mode;
  end

  // outputs to the analog side, pin and interrupt
  assign comp_enable              = ctrl_ff.enable; // [R1]
  assign reference_select         = ctrl_ff.ref_sel; // [R2]
  assign comparator_output_pin    = ctrl_ff.pin_en && out_state; // [R8]
  assign comparator_output_pin_oe = ctrl_ff.pin_en && ctrl_ff.enable; // [R8]
  assign compare_irq              = ctrl_ff.irq_en && flag_ff; // [R5] [R11]

endmodule : acmpc_top

// ### core/acmpc_pkg.sv
// Contract
// [R1] bit 7 is master enable; 0 turns the comparator function off
// [R2] bit 6 selects bandgap (1) or external pin (0) as plus input
// [R3] bit 5 flag sets on a comparator edge matching the event mode
// [R4] writing one to bit 5 clears the flag; writing zero leaves it
// [R5] irq asserted while bit 4 is one and the flag is set
// [R6] bit 3 reads the present comparator output level
// [R7] output state bit resets to 0 and reads 0 while disabled
// [R8] bit 2 one drives comparator output onto the output pin
// [R9] mode 00/10 falling, 01 rising, 11 either edge
// [R10] comparator output is one when plus input exceeds minus input
// [R11] in stop3 with enable set, keep comparing and flag, wake via irq
// [R12] after deepest stop wake, all bits return to reset values
// [R13] in background debug, keep comparing and flagging normally
// [R14] two-flop synchroniser on comparator output, edges from consecutive samples
// [R15] no flag set while disabled; reset clears all control bits and flag
package acmpc_pkg;
  localparam logic [31:0] ACMPC_OFS_SC    = 32'h0000_0000;
  localparam int          ACMPC_BIT_EN    = 7;
  localparam int          ACMPC_BIT_REF   = 6;
  localparam int          ACMPC_BIT_FLAG  = 5;
  localparam int          ACMPC_BIT_IE    = 4;
  localparam int          ACMPC_BIT_OUT   = 3;
  localparam int          ACMPC_BIT_PE    = 2;
  localparam logic [7:0]  ACMPC_SC_RESET  = 8'h00;
  localparam logic [1:0]  ACMPC_MODE_RISE = 2'h1;
  localparam logic [1:0]  ACMPC_MODE_BOTH = 2'h3;
  localparam int          ACMPC_MODE_HI   = 1;
  localparam int          ACMPC_MODE_LO   = 0;
  localparam logic [1:0]  ACMPC_HTRANS_NONSEQ = 2'h2;

  // software-writable control fields of the status/control register
  typedef struct packed {
    logic       enable;
    logic       ref_sel;
    logic       irq_en;
    logic       pin_en;
    logic [1:0] mode;
  } acmpc_ctrl_t;
endpackage : acmpc_pkg

// ### verif/acmpc_checker.sv
`timescale 1ns/1ps
module acmpc_checker
(
  // clock, reset and bus
  input wire logic        mclk, reset, hsel, hready, hwrite,
  input wire logic [1:0]  htrans,
  input wire logic [31:0] haddr, hwdata, hrdata,
  // comparator, pin and irq
  input wire logic        comp_raw, comp_enable, comparator_output_pin, comparator_output_pin_oe, compare_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // address phase at offset zero; calm input lets the synchroniser settle
  sequence acc_s(w);
    hsel && hready && htrans == 2'h2 && hwrite == w && haddr == 32'h0;
  endsequence
  sequence calm_s;
    ($stable(comp_raw) && comp_enable) [*5];
  endsequence
  // write of one to flag and irq enable while the comparator stays quiet
  sequence clr_s;
    calm_s ##0 acc_s(1'b1) ##1 (hwdata[5] && hwdata[4] && $stable(comp_raw));
  endsequence
  AST_PIN: assert property (comparator_output_pin |-> comparator_output_pin_oe) else $error("pin w/o oe");
  AST_OE_EN: assert property (comparator_output_pin_oe |-> comp_enable) else $error("oe w/o enable");
  AST_WR_EN: assert property (acc_s(1'b1) ##1 1'b1 |=> comp_enable == $past(hwdata[7])) else $error("enable");
  AST_RD_OFF: assert property (acc_s(1'b0) ##1 !comp_enable |-> !hrdata[3]) else $error("out bit off");
  AST_RD_OUT: assert property (calm_s ##0 acc_s(1'b0) |=> hrdata[3] == $past(comp_raw)) else $error("out bit");
  AST_PIN_VAL: assert property (calm_s |-> comparator_output_pin == (comparator_output_pin_oe & comp_raw))
    else $error("pin value");
  AST_W1C: assert property (clr_s |=> !compare_irq) else $error("flag clear");
  AST_IRQ_OFF: assert property (acc_s(1'b1) ##1 !hwdata[4] |=> !compare_irq) else $error("irq masked");
endmodule : acmpc_checker

// ### verif/acmpc_ana.sv
`timescale 1ns/1ps
module acmpc_ana
(
  // control and voltages
  input wire logic        ena, rsel,
  input wire logic [11:0] vp, vm, vbg,
  // comparator level
  output logic            out
);
  // ideal comparator, held low while powered off
  always_comb out = ena & ((rsel ? vbg : vp) > vm);
endmodule : acmpc_ana

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        mclk = 1'b0, reset = 1'b1, hwrite = 1'b0, pin, oe, irq, en, rs, craw, rdy;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
  logic [11:0] vp = 12'h200, vm = 12'h400, vbg = 12'h500;
  logic [7:0]  m;
  // rows: mode, rising input, flag expected
  logic [3:0]  rows [8] = '{4'h1, 4'h2, 4'h4, 4'h7, 4'h9, 4'ha, 4'hd, 4'hf};
  int          bad_count = 0, total_checks = 0;
  // 20 MHz clock
  always #25 mclk = ~mclk;
  acmpc_top uut (.mclk(mclk), .reset(reset), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata), .hreadyout(rdy), .hresp(), .comp_raw(craw),
    .comp_enable(en), .reference_select(rs), .comparator_output_pin(pin), .comparator_output_pin_oe(oe),
    .compare_irq(irq));
  acmpc_ana ana (.ena(en), .rsel(rs), .vp(vp), .vm(vm), .vbg(vbg), .out(craw));
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    bad_count += int'(got !== exp);
    if (got !== exp) $display("Error at %0t: got %h expected %h", $time, got, exp);
  endtask : chk
  // bounded wait for hready
  task automatic step();
    int n = 0;
    do @(posedge mclk); while (rdy !== 1'b1 && ++n < 64);
    bad_count += int'(rdy !== 1'b1);
    if (rdy !== 1'b1) print_verdict();
  endtask : step
  // one single word transfer; read data taken at the closing edge
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    step();
    htrans <= 2'h0;
    hwdata <= d;
    step();
    rdat = hrdata;
  endtask : acc
  initial
  begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    acc(1'b0, 32'h0, 32'h0);
    chk(rdat, 32'h0);
    foreach (rows[i])
    begin
      m = {6'h0, rows[i][3:2]};
      vp <= rows[i][1] ? 12'h200 : 12'h600;
      acc(1'b1, 32'h0, {24'h0, 8'h94 | m});
      repeat (8) @(posedge mclk);
      acc(1'b1, 32'h0, {24'h0, 8'hb4 | m});
      vp <= rows[i][1] ? 12'h600 : 12'h200;
      repeat (8) @(posedge mclk);
      acc(1'b0, 32'h0, 32'h0);
      chk(rdat, {24'h0, 8'h94 | m | {2'h0, rows[i][0], 1'b0, rows[i][1], 3'h0}});
      chk({30'h0, irq, pin}, {30'h0, rows[i][0], rows[i][1]});
    end
    // writing zero to the flag must keep it
    acc(1'b1, 32'h0, 32'h97);
    acc(1'b0, 32'h0, 32'h0);
    chk(rdat, 32'hbf);
    acc(1'b1, 32'h0, 32'h20);
    vp <= 12'h600;
    repeat (8) @(posedge mclk);
    acc(1'b0, 32'h0, 32'h0);
    chk(rdat, 32'h0);
    acc(1'b1, 32'h4, 32'hff);
    acc(1'b0, 32'h4, 32'h0);
    chk(rdat, 32'h0);
    acc(1'b1, 32'h0, 32'hc0);
    repeat (8) @(posedge mclk);
    acc(1'b0, 32'h0, 32'h0);
    chk(rdat, 32'hc8);
    vbg <= 12'h300;
    repeat (8) @(posedge mclk);
    acc(1'b0, 32'h0, 32'h0);
    chk(rdat, 32'he0);
    chk({31'h0, irq}, 32'h0);
    // reset in mid-run returns every bit to its reset value
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    acc(1'b0, 32'h0, 32'h0);
    chk(rdat, 32'h0);
    chk({30'h0, irq, oe}, 32'h0);
    print_verdict();
  end
endmodule : testbench
bind acmpc_top acmpc_checker chk_i (.*);
